// File: dpb_pkg.sv
package dpb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // array geometry
  localparam int TOTAL_BITS = 18432;
  localparam int PLAIN_BITS = 16384;
  localparam int DEPTH_X9 = 2048;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 36;
  localparam int PTR_W = 15;
  localparam int INIT_STEP = 32;

  ////////////////////////////////////////////////////////////////////////////
  // field codes
  localparam logic [2:0] WID_1 = 3'h0;
  localparam logic [2:0] WID_2 = 3'h1;
  localparam logic [2:0] WID_4 = 3'h2;
  localparam logic [2:0] WID_9 = 3'h3;
  localparam logic [2:0] WID_18 = 3'h4;
  localparam logic [2:0] WID_36 = 3'h5;

  localparam logic [1:0] WM_NORMAL = 2'h0;
  localparam logic [1:0] WM_THROUGH = 2'h1;
  localparam logic [1:0] WM_RBW = 2'h2;

  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_TRUE_DUAL = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG_A = 8'h04;
  localparam logic [7:0] REG_CFG_B = 8'h08;
  localparam logic [7:0] REG_INIT_PTR = 8'h0C;
  localparam logic [7:0] REG_INIT_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CFG_WID_LSB = 0;
  localparam int CFG_WM_LSB = 3;
  localparam int CFG_OREG_BIT = 5;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_WID_A_LSB = 1;
  localparam int ST_WID_B_LSB = 4;
  localparam int ST_RBW_A_BIT = 7;
  localparam int ST_RBW_B_BIT = 8;
  localparam int ST_COLL_BIT = 9;

  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 15'h0000;

  ////////////////////////////////////////////////////////////////////////////
  function automatic int width_bits(input logic [2:0] code);
    unique case (code)
      WID_2: return 2;
      WID_4: return 4;
      WID_9: return 9;
      WID_18: return 18;
      WID_36: return 36;
      default: return 1;
    endcase
  endfunction

  function automatic int depth_of(input logic [2:0] code);
    if (code <= WID_4)
      return PLAIN_BITS / width_bits(code);
    return DEPTH_X9 / (width_bits(code) / 9);
  endfunction

endpackage

// File: dpb_port_pipe.sv
`timescale 1ns/1ps
module dpb_port_pipe
  import dpb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  input wire logic we,
  input wire logic [dpb_pkg::ADDR_W-1:0] addr,
  input wire logic [dpb_pkg::DATA_W-1:0] wdata,
  input wire logic oreg,
  input wire logic [1:0] wmode,
  input wire logic acc,
  input wire logic wr,
  input wire logic [dpb_pkg::DATA_W-1:0] rd_word,
  input wire logic [dpb_pkg::DATA_W-1:0] thru_word,
  output logic en_q,
  output logic we_q,
  output logic [dpb_pkg::ADDR_W-1:0] addr_q,
  output logic [dpb_pkg::DATA_W-1:0] wd_q,
  output logic [dpb_pkg::DATA_W-1:0] rdata
);
  import dpb_pkg::*;

  logic upd;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] stage;

  ////////////////////////////////////////////////////////////////////////////
  // input capture ahead of the array
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
    end
    else
    begin
      en_q <= en;
      we_q <= we;
      addr_q <= addr;
      wd_q <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // what the port shows for this array cycle
  always_comb
  begin
    upd = 1'b0;
    val = rd_word;
    if (acc && !wr)
      upd = 1'b1;
    else if (acc && wr)
    begin
      unique case (wmode)
        WM_THROUGH:
        begin
          upd = 1'b1;
          val = thru_word;
        end
        WM_RBW: upd = 1'b1;
        default: upd = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the last stage is always a flop; the output register just inserts one more
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage <= '0;
      rdata <= '0;
    end
    else
    begin
      if (upd)
        stage <= val;
      if (oreg)
        rdata <= stage;
      else if (upd)
        rdata <= val;
    end
  end

endmodule // dpb_port_pipe

// File: dpb_ram.sv
`timescale 1ns/1ps
// Contract
// - each port has its own width and depth in every multi-port mode
// - bits map word 0 lsb..msb, then word 1, for every port width
// - contents can be preloaded before user operation starts
// - port data and address are registered before the array access
// - each port read path has an optional output register stage
// - normal mode: output changes only on reads, never on writes
// - write-through mode: written data appears on that port's output
// - read-before-write shows old content; only for 9, 18, 36 widths
// - shapes 16384x1..512x36; true dual port at most 1024x18
module dpb_ram
  import dpb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [dpb_pkg::ADDR_W-1:0] a_addr,
  input wire logic [dpb_pkg::DATA_W-1:0] a_wdata,
  output logic [dpb_pkg::DATA_W-1:0] a_rdata,
  input wire logic b_en,
  input wire logic b_we,
  input wire logic [dpb_pkg::ADDR_W-1:0] b_addr,
  input wire logic [dpb_pkg::DATA_W-1:0] b_wdata,
  output logic [dpb_pkg::DATA_W-1:0] b_rdata
);
  import dpb_pkg::*;

  logic [TOTAL_BITS-1:0] mem;
  logic [1:0] mode;
  logic run;
  logic [5:0] cfg_a;
  logic [5:0] cfg_b;
  logic [PTR_W-1:0] init_ptr;
  logic coll;
  logic dp_wr;
  logic dp_rd;
  logic [7:0] dp_addr;
  logic [31:0] reg_val;
  logic wr_ctrl;
  logic wr_cfg_a;
  logic wr_cfg_b;
  logic wr_ptr;
  logic init_wr;
  logic clr_coll;
  logic a_en_q;
  logic a_we_q;
  logic [ADDR_W-1:0] a_addr_q;
  logic [DATA_W-1:0] a_wd_q;
  logic b_en_q;
  logic b_we_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [DATA_W-1:0] b_wd_q;
  logic [2:0] a_wid;
  logic [2:0] b_wid;
  logic [1:0] a_wm;
  logic [1:0] b_wm;
  int a_w;
  int b_w;
  int a_base;
  int b_base;
  logic a_acc;
  logic a_wr;
  logic b_acc;
  logic b_wr;
  logic a_overlap;
  logic [DATA_W-1:0] a_rd_word;
  logic [DATA_W-1:0] b_rd_word;
  logic [DATA_W-1:0] a_thru;
  logic [DATA_W-1:0] b_thru;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] eff_width(input logic [2:0] code, input logic [1:0] md);
    if (code > WID_36)
      return WID_1;
    if (md == MODE_TRUE_DUAL && code == WID_36)
      return WID_18;
    return code;
  endfunction

  function automatic logic [1:0] eff_wmode(input logic [1:0] wm, input logic [2:0] code);
    if (wm == WM_RBW && code >= WID_9)
      return WM_RBW;
    if (wm == WM_THROUGH)
      return WM_THROUGH;
    return WM_NORMAL;
  endfunction

  // gathers a word from the linear bit array, zeros above the port width
  function automatic logic [DATA_W-1:0] pick(input logic [TOTAL_BITS-1:0] arr, input int base, input int w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++)
      if (i < w && base + i < TOTAL_BITS)
        r[i] = arr[base+i];
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] width_mask(input int w);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++)
      if (i < w)
        m[i] = 1'b1;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes are zero-wait, reads take one wait state so that
  // a read right behind a write sees the written value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end
    else
    begin
      dp_wr <= 1'b0;
      if (dp_rd)
      begin
        dp_rd <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= reg_val;
      end
      else if (hsel && htrans[1] && hready)
      begin
        dp_addr <= haddr[7:0];
        dp_wr <= hwrite;
        dp_rd <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  always_comb
  begin
    wr_ctrl = dp_wr && dp_addr == REG_CTRL;
    wr_cfg_a = dp_wr && dp_addr == REG_CFG_A && !run;
    wr_cfg_b = dp_wr && dp_addr == REG_CFG_B && !run;
    wr_ptr = dp_wr && dp_addr == REG_INIT_PTR && !run;
    init_wr = dp_wr && dp_addr == REG_INIT_DATA && !run;
    clr_coll = dp_wr && dp_addr == REG_STATUS && hwdata[ST_COLL_BIT];
  end

  always_comb
  begin
    reg_val = 32'h00000000;
    unique case (dp_addr)
      REG_CTRL:
      begin
        reg_val[CTRL_MODE_LSB +: 2] = mode;
        reg_val[CTRL_RUN_BIT] = run;
      end
      REG_CFG_A: reg_val[5:0] = cfg_a;
      REG_CFG_B: reg_val[5:0] = cfg_b;
      REG_INIT_PTR: reg_val[PTR_W-1:0] = init_ptr;
      REG_STATUS:
      begin
        reg_val[ST_RUN_BIT] = run;
        reg_val[ST_WID_A_LSB +: 3] = a_wid;
        reg_val[ST_WID_B_LSB +: 3] = b_wid;
        reg_val[ST_RBW_A_BIT] = a_wm == WM_RBW;
        reg_val[ST_RBW_B_BIT] = b_wm == WM_RBW;
        reg_val[ST_COLL_BIT] = coll;
      end
      default: reg_val = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration; shape and write mode are frozen while the array runs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode <= MODE_RST;
      run <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      if (!run)
        mode <= hwdata[CTRL_MODE_LSB +: 2];
      run <= hwdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_a <= CFG_RST;
      cfg_b <= CFG_RST;
    end
    else
    begin
      if (wr_cfg_a)
        cfg_a <= hwdata[5:0];
      if (wr_cfg_b)
        cfg_b <= hwdata[5:0];
    end
  end

  // preload pointer walks the array in bit order, one data word per write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      init_ptr <= PTR_RST;
    else if (wr_ptr)
      init_ptr <= hwdata[PTR_W-1:0];
    else if (init_wr)
      init_ptr <= init_ptr + PTR_W'(INIT_STEP);
  end

  // sticky: a collision in the clearing cycle still sets the flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      coll <= 1'b0;
    else if (a_wr && b_wr && a_overlap)
      coll <= 1'b1;
    else if (clr_coll)
      coll <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective port shapes and access qualification
  always_comb
  begin
    a_wid = eff_width(cfg_a[CFG_WID_LSB +: 3], mode);
    b_wid = eff_width(cfg_b[CFG_WID_LSB +: 3], mode);
    a_wm = eff_wmode(cfg_a[CFG_WM_LSB +: 2], a_wid);
    b_wm = eff_wmode(cfg_b[CFG_WM_LSB +: 2], b_wid);
    a_w = width_bits(a_wid);
    b_w = width_bits(b_wid);
    a_base = int'(a_addr_q) * a_w;
    b_base = int'(b_addr_q) * b_w;
    // pseudo dual port: a writes only, b reads only; single port: b is off
    a_acc = run && a_en_q && int'(a_addr_q) < depth_of(a_wid) && !(mode == MODE_PSEUDO && !a_we_q);
    b_acc = run && b_en_q && int'(b_addr_q) < depth_of(b_wid) && mode != MODE_SINGLE
      && !(mode == MODE_PSEUDO && b_we_q);
    a_wr = a_acc && a_we_q;
    b_wr = b_acc && b_we_q;
    a_overlap = a_base < b_base + b_w && b_base < a_base + a_w;
    a_rd_word = pick(mem, a_base, a_w);
    b_rd_word = pick(mem, b_base, b_w);
    a_thru = a_wd_q & width_mask(a_w);
    b_thru = b_wd_q & width_mask(b_w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // the array; not reset, it keeps preloaded contents. on a same-bit clash
  // port b lands last, but the value is to be taken as undefined
  always_ff @(posedge hclk)
  begin
    if (init_wr)
      for (int i = 0; i < INIT_STEP; i++)
        if (int'(init_ptr) + i < TOTAL_BITS)
          mem[int'(init_ptr)+i] <= hwdata[i];
    if (a_wr)
      for (int i = 0; i < DATA_W; i++)
        if (i < a_w)
          mem[a_base+i] <= a_wd_q[i];
    if (b_wr)
      for (int i = 0; i < DATA_W; i++)
        if (i < b_w)
          mem[b_base+i] <= b_wd_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // port pipelines
  dpb_port_pipe u_port_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(a_en),
    .we(a_we),
    .addr(a_addr),
    .wdata(a_wdata),
    .oreg(cfg_a[CFG_OREG_BIT]),
    .wmode(a_wm),
    .acc(a_acc),
    .wr(a_wr),
    .rd_word(a_rd_word),
    .thru_word(a_thru),
    .en_q(a_en_q),
    .we_q(a_we_q),
    .addr_q(a_addr_q),
    .wd_q(a_wd_q),
    .rdata(a_rdata)
  );

  dpb_port_pipe u_port_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(b_en),
    .we(b_we),
    .addr(b_addr),
    .wdata(b_wdata),
    .oreg(cfg_b[CFG_OREG_BIT]),
    .wmode(b_wm),
    .acc(b_acc),
    .wr(b_wr),
    .rd_word(b_rd_word),
    .thru_word(b_thru),
    .en_q(b_en_q),
    .we_q(b_we_q),
    .addr_q(b_addr_q),
    .wd_q(b_wd_q),
    .rdata(b_rdata)
  );

endmodule // dpb_ram

// File: dpb_chk.sv
`timescale 1ns/1ps
module dpb_chk
  import dpb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [dpb_pkg::ADDR_W-1:0] a_addr,
  input wire logic [dpb_pkg::DATA_W-1:0] a_wdata,
  input wire logic [dpb_pkg::DATA_W-1:0] a_rdata,
  input wire logic b_en,
  input wire logic [dpb_pkg::DATA_W-1:0] b_rdata
);
  import dpb_pkg::*;
  logic pend;
  logic run;
  logic [1:0] mode;
  logic [5:0] cfg;
  logic [7:0] pa;
  logic act;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // shadow of the setup, so the port a write checks only fire on a known x36 single-port setup
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= 1'b0;
      pa <= 8'h00;
      run <= 1'b0;
      mode <= MODE_SINGLE;
      cfg <= 6'h00;
    end
    else
    begin
      pend <= hsel && htrans[1] && hready && hwrite;
      pa <= haddr[7:0];
      if (pend && pa == REG_CTRL)
        run <= hwdata[CTRL_RUN_BIT];
      if (pend && pa == REG_CTRL && !run)
        mode <= hwdata[1:0];
      if (pend && pa == REG_CFG_A && !run)
        cfg <= hwdata[5:0];
    end
  end
  assign act = run && mode == MODE_SINGLE && cfg[2:0] == WID_36 && a_en && a_addr < 14'h0200;
  sequence s_wr(logic [1:0] m);
    act && a_we && !cfg[5] && cfg[4:3] == m;
  endsequence
  ////////////////////////////////////////
  a_hresp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  // an access sampled at edge e moves rdata at e+1, or at e+2 with the output register,
  // so the new value is first seen when sampling at e+2 or e+3
  a_a_hold: assert property (!$past(a_en) && !$past(a_en, 2) && !$past(a_en, 3) |-> $stable(a_rdata))
    else $error("port a output moved without access");
  a_b_hold: assert property (!$past(b_en) && !$past(b_en, 2) && !$past(b_en, 3) |-> $stable(b_rdata))
    else $error("port b output moved without access");
  a_thru_echo: assert property (s_wr(WM_THROUGH) |-> ##2 a_rdata == $past(a_wdata, 2))
    else $error("write-through data missing");
  a_normal_quiet: assert property (s_wr(WM_NORMAL) |-> ##2 $stable(a_rdata))
    else $error("normal write changed output");
  a_rbw_old: assert property (s_wr(WM_RBW) ##1 (act && a_we && $stable(a_addr)) |->
    ##2 a_rdata == $past(a_wdata, 3)) else $error("old content not shown");
  a_raw_new: assert property (s_wr(WM_NORMAL) ##1 (act && !a_we && $stable(a_addr)) |->
    ##2 a_rdata == $past(a_wdata, 3)) else $error("read after write stale");
  a_oreg_lat: assert property (act && a_we && cfg[5] && cfg[4:3] == WM_THROUGH |->
    ##3 a_rdata == $past(a_wdata, 3)) else $error("output register latency wrong");
endmodule // dpb_chk

bind dpb_ram dpb_chk u_dpb_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .a_en(a_en),
  .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata), .b_en(b_en), .b_rdata(b_rdata));

// File: dpb_user.sv
`timescale 1ns/1ps
module dpb_user
  import dpb_pkg::*;
(
  input wire logic hclk,
  input wire logic rom,
  input wire logic [dpb_pkg::DATA_W-1:0] rdata,
  output logic en,
  output logic we,
  output logic [dpb_pkg::ADDR_W-1:0] addr,
  output logic [dpb_pkg::DATA_W-1:0] wdata
);
  import dpb_pkg::*;
  initial
  begin
    en = 1'b0;
    we = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // lat 0 leaves the request up, so the next call lands back to back;
  // otherwise lat counts edges after the one that captures the request
  task automatic op(input logic w, input logic [13:0] ad, input logic [35:0] d, input int lat,
    output logic [35:0] rd);
    @(posedge hclk);
    en <= 1'b1;
    we <= w & ~rom;
    addr <= ad;
    wdata <= d;
    if (lat > 0)
    begin
      @(posedge hclk);
      en <= 1'b0;
      we <= 1'b0;
      addr <= ~ad;
      wdata <= ~d;
      repeat (lat) @(posedge hclk);
      #1 rd = rdata;
    end
  endtask
endmodule // dpb_user

// File: dpb_tb.sv
`timescale 1ns/1ps
module testbench;
  import dpb_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic rom = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r32;
  logic hready, hresp, a_en, a_we, b_en, b_we;
  logic [13:0] a_addr, b_addr;
  logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata, r, rb;
  int err_count = 0;
  int tests_run = 0;
  always #20 hclk = ~hclk;
  dpb_ram u_dpb_ram (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata),
    .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata));
  dpb_user u_usr_a (.hclk(hclk), .rom(rom), .rdata(a_rdata), .en(a_en), .we(a_we), .addr(a_addr),
    .wdata(a_wdata));
  dpb_user u_usr_b (.hclk(hclk), .rom(rom), .rdata(b_rdata), .en(b_en), .we(b_we), .addr(b_addr),
    .wdata(b_wdata));
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r32);
  endtask
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [35:0] e);
    bus(1'b0, a, 32'h0, r32);
    chk("register", e, {4'h0, r32});
  endtask
  // setup only sticks while stopped, so stop, load, then restart
  task automatic cfg(input logic [1:0] m, input logic [5:0] ca, input logic [5:0] cb);
    wr(REG_CTRL, {30'h0, m});
    wr(REG_CFG_A, {26'h0, ca});
    wr(REG_CFG_B, {26'h0, cb});
    wr(REG_CTRL, {29'h0, 1'b1, m});
  endtask
  task automatic summarize;
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdreg(REG_STATUS, 36'h0);
    rdreg(8'h40, 36'h0);
    wr(REG_INIT_PTR, 32'h0);
    wr(REG_INIT_DATA, 32'h89ABCDEF);
    wr(REG_INIT_DATA, 32'h00000005);
    cfg(MODE_SINGLE, {1'b0, WM_NORMAL, WID_36}, 6'h00);
    wr(REG_CFG_A, 32'h0);
    rdreg(REG_STATUS, 36'h00B);
    rom <= 1'b1;
    u_usr_a.op(1'b1, 14'h0000, 36'h0, 1, r);
    rom <= 1'b0;
    u_usr_a.op(1'b0, 14'h0000, 36'h0, 1, r);
    chk("preload", 36'h589ABCDEF, r);
    for (int m = 0; m < 3; m++)
    begin
      cfg(MODE_SINGLE, {1'b0, 2'(m), WID_36}, 6'h00);
      u_usr_a.op(1'b0, 14'h0000, 36'h0, 1, r);
      u_usr_a.op(1'b1, 14'h0003, 36'h123456789, 0, r);
      u_usr_a.op(1'b1, 14'h0003, 36'hA5A5A5A50 + m, 1, r);
      chk("write_mode", m == 0 ? 36'h589ABCDEF : m == 1 ? 36'hA5A5A5A50 + m : 36'h123456789, r);
      u_usr_a.op(1'b1, 14'h0004, 36'hC3C3C3C30 + m, 0, r);
      u_usr_a.op(1'b0, 14'h0004, 36'h0, 1, r);
      chk("read_after_write", 36'hC3C3C3C30 + m, r);
    end
    cfg(MODE_SINGLE, {1'b1, WM_THROUGH, WID_36}, 6'h00);
    u_usr_a.op(1'b1, 14'h0005, 36'h0F0F0F0F1, 2, r);
    chk("oreg_write", 36'h0F0F0F0F1, r);
    u_usr_a.op(1'b0, 14'h0004, 36'h0, 2, r);
    chk("oreg_read", 36'hC3C3C3C32, r);
    cfg(MODE_PSEUDO, {1'b0, WM_NORMAL, WID_36}, {1'b0, WM_NORMAL, WID_9});
    u_usr_a.op(1'b1, 14'h0002, 36'hF1E2D3C4B, 1, r);
    for (int k = 0; k < 4; k++)
    begin
      u_usr_b.op(1'b0, 14'(8 + k), 36'h0, 1, r);
      chk("narrow_word", (36'hF1E2D3C4B >> (9 * k)) & 36'h1FF, r);
    end
    cfg(MODE_TRUE_DUAL, {1'b0, WM_RBW, WID_36}, {1'b0, WM_RBW, WID_4});
    // both ports write in one cycle, but never the same bits
    fork
      u_usr_a.op(1'b1, 14'h0001, 36'h0, 1, r);
      u_usr_b.op(1'b1, 14'h0064, 36'h6, 1, rb);
    join
    chk("rbw_x18", 36'h00001626A, r);
    chk("rbw_fallback", 36'h0000001E3, rb);
    wr(REG_STATUS, 32'h00000200);
    rdreg(REG_STATUS, 36'h0A9);
    summarize();
  end
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule // testbench
